// *** rtl/cps_sequencer.sv ***
// charger power-up sequencer with AHB-Lite register slave
//
// Contract
// [RL1] Reset starts power-on state: bus usable, every register at default.
// [RL2] Battery only: close battery switch above depletion level, regulator stays off.
// [RL3] Discharge overcurrent on battery: open switch, set disable bit, stay shipped.
// [RL4] Supply attach: regulator, source check, port type and limit, regulation, buck.
// [RL5] Regulator on after 220 ms above margin or boost; off in hz, overvoltage.
// [RL6] Source check: no overvoltage, above bad level, test sink; retry each 2 s.
// [RL7] After supply good: detect type or sample select pin; ready bits, interrupt.
// [RL8] Write port code; load limit from detection only while auto bit is 1.
// [RL9] Limit field 50 mA to 3.2 A in 50 mA steps; host writes anytime.
// [RL10] Select-pin variant updates limit continuously: high 0.5 A, low 2.4 A.
// [RL11] Data-line results map to fixed limit and port code table.
// [RL12] Data-line variant reapplies detection on enable bit re-set or reattach.
// [RL13] Regulation setting defaults 4.5 V, 3.9 V to 5.4 V in 0.1 V.
// [RL14] Tracking on: target is max of setting and battery plus offset.
// [RL15] Buck after limit set; switch on unless charge off or shipped; light-load disable.
// [RL16] Boost needs battery, low input, enable, thermistor ok, 30 ms after enable.
// [RL17] Boost reports state 1111, defaults 5.15 V and 1.2 A, configurable.
// [RL18] Host restarts watchdog before timeout; period 00 disables it.
// [RL19] Expiry sets watchdog bits, interrupt, defaults 512 ms later; writes restart.
// [RL20] Disable bit opens switch at once; delayed bit opens after entry delay.
// [RL21] Leave shipping on attach, bit clear, register reset, or long button press.
// [RL22] Button held past reset time without supply: open switch for interval.
// [RL23] Delayed shipping entry takes 12 s from setting the delayed bit.
// [RL24] Button low time to leave shipping is 1.1 s.
// [RL25] Button low time to reset the system is 10 s.
// [RL26] Button timer restarts whenever the pin returns high early.
//
// Register access over AHB-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module cps_sequencer
  import cps_pkg::*;
#(
  parameter bit HAS_DATA_LINES = 1'b1,
  parameter logic [TW-1:0] CYC_PER_MS = TW'(MS_NS / CLK_PERIOD_NS),
  parameter logic [TW-1:0] RETRY_MS = TW'(SRC_RETRY_MS),
  parameter logic [TW-1:0] SHIP_MS = TW'(SHIP_ENTER_MS),
  parameter logic [TW-1:0] BRST_MS = TW'(BTN_RST_MS),
  parameter logic [TW-1:0] WDT_MS = TW'(WDT_BASE_MS)
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic [31:0] hrdata_o,
  output logic hresp_o,
  input wire logic supply_above_sleep_i,
  input wire logic supply_below_sleep_fall_i,
  input wire logic supply_overvoltage_i,
  input wire logic supply_above_bad_adapter_i,
  input wire logic battery_above_depletion_i,
  input wire logic battery_above_low_i,
  input wire logic discharge_overcurrent_i,
  input wire logic thermistor_in_range_i,
  input wire logic push_button_pin_n_i,
  input wire logic select_pin_i,
  input wire logic detect_done_i,
  input wire logic [2:0] detect_type_i,
  input wire logic [6:0] battery_voltage_i,
  output logic gate_drive_regulator_en_o,
  output logic test_sink_en_o,
  output logic detect_start_o,
  output logic buck_en_o,
  output logic light_load_mode_disable_o,
  output logic boost_en_o,
  output logic battery_switch_on_o,
  output logic [5:0] input_current_limit_o,
  output logic [6:0] input_voltage_target_o,
  output logic [3:0] boost_voltage_o,
  output logic boost_current_high_o,
  output logic [3:0] charger_state_code_o,
  output logic int_n_o
);
  localparam logic [TW-1:0] K_GATE_DRIVE_REGULATOR = TW'(GATE_DRIVE_REGULATOR_DLY_MS);
  localparam logic [TW-1:0] K_CHK = TW'(SRC_CHK_MS);
  localparam logic [TW-1:0] K_BOOST = TW'(BOOST_DLY_MS);
  localparam logic [TW-1:0] K_WDW = TW'(WDT_WAIT_MS);
  localparam logic [TW-1:0] K_EXIT = TW'(SHIP_EXIT_MS);
  localparam logic [TW-1:0] K_BSW = TW'(BSW_RST_MS);
  typedef struct packed {
    logic [NSI-1:0] s1, s2, s3, f;
    cps_state_e st;
    logic [TW-1:0] tk, tm, wd, ww, sh, bt, br;
    logic wx, ba, dp;
    logic [31:0] ctrl, lim;
    logic sg, cr, ws, sgf, crf, wdf;
    logic [3:0] port, csc;
    logic rg, sk, ds, bk, bo, sw, irq_n;
    logic [6:0] vt;
    logic av, aw, as, rdy;
    logic [7:0] aa;
    logic [31:0] rd;
  } cps_state_s;
  cps_state_s r, n;
  logic [NSI-1:0] raw;
  logic ms, lost, bok, pr, wok, rgo, acc, ev;
  logic up, ovp, bad, dpl, ocp;
  logic [TW-1:0] wl;
  logic [6:0] vb, vk;
  assign raw = {detect_done_i, select_pin_i, push_button_pin_n_i, thermistor_in_range_i,
                discharge_overcurrent_i, battery_above_low_i, battery_above_depletion_i,
                supply_above_bad_adapter_i, supply_overvoltage_i, supply_below_sleep_fall_i,
                supply_above_sleep_i};
  assign up = r.f[SI_UP];
  assign ovp = r.f[SI_OVP];
  assign bad = r.f[SI_BAD];
  assign dpl = r.f[SI_DPL];
  assign ocp = r.f[SI_OCP];
  always_comb begin
    n = r;
    ev = 1'b0;
    ms = (r.tk == CYC_PER_MS - 1'b1);
    lost = !up || r.ctrl[B_HZ] || ovp;
    bok = r.f[SI_LBP] && r.f[SI_SLPF] && r.ctrl[B_OTG] && r.f[SI_TS];
    pr = !r.f[SI_BTN_N];
    acc = hsel_i && htrans_i[1] && hready_i;
    wok = r.av && r.aw && r.as;
    rgo = r.av && !r.aw;
    wl = (r.lim[F_WDP+:2] == 2'b01) ? WDT_MS :
         (r.lim[F_WDP+:2] == 2'b10) ? {WDT_MS[TW-2:0], 1'b0} : {WDT_MS[TW-3:0], 2'b00};
    vb = INPUT_VOLTAGE_REGULATION_BASE_DV + {3'b000, r.lim[F_INPUT_VOLTAGE_REGULATION+:4]};
    vk = battery_voltage_i + {5'b00000, r.lim[F_TRK+:2]};
    // a pin change counts once the second and third stages agree
    n.s1 = raw;
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.f = (r.s2 & r.s3) | (r.f & (r.s2 | r.s3));
    n.tk = ms ? '0 : r.tk + 1'b1;
    n.tm = ms ? r.tm + 1'b1 : r.tm;
    // bus: writes complete at once, reads take one wait state
    n.av = 1'b0;
    n.rdy = 1'b1;
    if (acc) begin
      n.av = 1'b1;
      n.aw = hwrite_i;
      n.as = (hsize_i == HSIZE_WORD);
      n.aa = haddr_i[7:0];
      n.rdy = hwrite_i;
    end
    if (rgo) begin
      n.rd = '0;
      if (r.aa == REG_CTRL) begin
        n.rd = r.ctrl;
      end else if (r.aa == REG_LIMIT) begin
        n.rd = r.lim;
      end else if (r.aa == REG_STATUS) begin
        n.rd[B_SG] = r.sg;
        n.rd[B_CR] = r.cr;
        n.rd[B_WDS] = r.ws;
        n.rd[B_SHIP] = r.ctrl[B_DIS];
        n.rd[F_PORT+:4] = r.port;
        n.rd[F_CSC+:4] = r.csc;
      end else if (r.aa == REG_FLAGS) begin
        n.rd[B_SG] = r.sgf;
        n.rd[B_CR] = r.crf;
        n.rd[B_WDS] = r.wdf;
      end
    end
    if (wok) begin
      if (r.aa == REG_CTRL) begin
        n.ctrl = hwdata_i & CTRL_WMASK; // RL20
        if (hwdata_i[B_REGRST]) begin
          n.ctrl = CTRL_RST; // RL21
          n.lim = LIM_RST; // RL1
        end
      end else if (r.aa == REG_LIMIT) begin
        n.lim = hwdata_i & LIM_WMASK; // RL9 RL13 RL17
      end else if (r.aa == REG_FLAGS) begin
        n.sgf = r.sgf && !hwdata_i[B_SG];
        n.crf = r.crf && !hwdata_i[B_CR];
        n.wdf = r.wdf && !hwdata_i[B_WDS];
      end
    end

    // watchdog; any accepted word-size write, counter reset included, restarts it
    if (wok) begin
      n.wd = '0; // RL19
      n.wx = 1'b0;
      n.ww = '0;
      n.ws = 1'b0;
    end else if (r.lim[F_WDP+:2] == 2'b00) begin
      n.wd = '0; // RL18
    end else if (!r.wx) begin
      if (ms) n.wd = r.wd + 1'b1;
      if (r.wd >= wl) begin
        n.wx = 1'b1; // RL19
        n.ws = 1'b1;
        n.wdf = 1'b1;
        ev = 1'b1;
      end
    end else if (ms && r.ww < K_WDW) begin
      n.ww = r.ww + 1'b1;
      if (r.ww == K_WDW - 1'b1) begin
        n.lim = LIM_RST; // RL19
        n.ctrl = (r.ctrl & ~WDT_CTRL_MASK) | (CTRL_RST & WDT_CTRL_MASK);
      end
    end

    // power-up sequence
    n.ds = 1'b0;
    case (r.st)
      ST_OFF: begin
        if (!lost) begin
          n.st = ST_GATE_DRIVE_REGULATOR_WAIT; // RL4
          n.tm = '0;
          n.ctrl[B_DIS] = 1'b0; // RL21
        end else if (bok) begin
          n.st = ST_BOOST_WAIT; // RL16
          n.tm = '0;
        end
      end
      ST_GATE_DRIVE_REGULATOR_WAIT: begin
        if (lost) begin
          n.st = ST_OFF;
        end else if (r.tm >= K_GATE_DRIVE_REGULATOR) begin
          n.st = ST_SRC_CHECK; // RL5
          n.tm = '0;
        end
      end
      ST_SRC_CHECK: begin
        if (lost) begin
          n.st = ST_OFF;
        end else if (r.tm >= K_CHK) begin
          n.tm = '0;
          if (!ovp && bad) begin
            n.st = ST_DETECT; // RL6
            n.sg = 1'b1;
            n.sgf = 1'b1;
            ev = 1'b1;
          end else begin
            n.st = ST_SRC_RETRY; // RL6
          end
        end
      end
      ST_SRC_RETRY: begin
        if (lost) begin
          n.st = ST_OFF;
        end else if (r.tm >= RETRY_MS) begin
          n.st = ST_SRC_CHECK; // RL6
          n.tm = '0;
        end
      end
      ST_DETECT: begin
        n.ds = HAS_DATA_LINES;
        if (lost) begin
          n.st = ST_OFF;
        end else if (!HAS_DATA_LINES || r.f[SI_DET]) begin
          n.ds = 1'b0;
          n.st = ST_INPUT_VOLTAGE_REGULATION; // RL7
          n.cr = 1'b1;
          n.crf = 1'b1;
          ev = 1'b1;
          if (HAS_DATA_LINES) begin
            n.port = {PORT_DET_MSB, detect_type_i}; // RL8 RL11
            if (r.ctrl[B_AUTO]) n.lim[F_ICL+:6] = DET_ICL[6*detect_type_i+:6]; // RL8
          end else begin
            n.port = r.f[SI_SEL] ? PORT_SEL_HI : PORT_SEL_LO; // RL10
            if (r.ctrl[B_AUTO]) n.lim[F_ICL+:6] = r.f[SI_SEL] ? ICL_SEL_HI : ICL_SEL_LO;
          end
        end
      end
      ST_INPUT_VOLTAGE_REGULATION: n.st = ST_BUCK; // RL4 RL15
      ST_BUCK: begin
        if (lost) begin
          n.st = ST_OFF;
        end else if (HAS_DATA_LINES && r.ctrl[B_DETEN] && !r.dp) begin
          n.st = ST_DETECT; // RL12
        end else if (!HAS_DATA_LINES) begin
          n.port = r.f[SI_SEL] ? PORT_SEL_HI : PORT_SEL_LO; // RL10
          if (r.ctrl[B_AUTO]) n.lim[F_ICL+:6] = r.f[SI_SEL] ? ICL_SEL_HI : ICL_SEL_LO;
        end
      end
      ST_BOOST_WAIT: begin
        if (!bok) begin
          n.st = ST_OFF;
        end else if (r.tm >= K_BOOST) begin
          n.st = ST_BOOST; // RL16
        end
      end
      ST_BOOST: if (!bok) n.st = ST_OFF; // RL17
      default: n.st = ST_OFF;
    endcase
    n.dp = r.ctrl[B_DETEN];
    if (n.st == ST_OFF) begin
      n.sg = 1'b0;
      n.cr = 1'b0;
    end

    // shipping mode and push button; hardware sets beat host clears
    if (!pr) begin
      n.bt = '0; // RL26
    end else if (ms && r.bt < BRST_MS) begin
      n.bt = r.bt + 1'b1;
      if (r.bt == K_EXIT - 1'b1) n.ctrl[B_DIS] = 1'b0; // RL21 RL24
      if (r.bt == BRST_MS - 1'b1 && !up && r.ctrl[B_RSTEN]) begin
        n.ba = 1'b1; // RL22 RL25
        n.br = '0;
      end
    end
    if (r.ba) begin
      if (ms) n.br = r.br + 1'b1;
      if (r.br >= K_BSW) n.ba = 1'b0; // RL22
    end
    if (r.ctrl[B_DLY]) begin
      if (ms) n.sh = r.sh + 1'b1;
      if (r.sh >= SHIP_MS) begin
        n.ctrl[B_DIS] = 1'b1; // RL20 RL23
        n.ctrl[B_DLY] = 1'b0;
        n.sh = '0;
      end
    end else begin
      n.sh = '0;
    end
    if (r.st != ST_BUCK && ocp && r.sw) begin
      n.ctrl[B_DIS] = 1'b1; // RL3
      n.ctrl[B_DLY] = 1'b0;
    end

    // registered outputs
    n.rg = !(n.st == ST_OFF || n.st == ST_GATE_DRIVE_REGULATOR_WAIT); // RL5 RL2
    n.sk = (n.st == ST_SRC_CHECK); // RL6
    n.bk = (n.st == ST_BUCK);
    n.bo = (n.st == ST_BOOST);
    n.csc = n.bo ? CSC_BOOST : n.bk ? CSC_BUCK : CSC_IDLE; // RL17
    n.sw = !n.ctrl[B_DIS] && !n.ba && (n.bk ? n.ctrl[B_CHGEN] : dpl); // RL2 RL15 RL20
    n.vt = (r.lim[F_TRK+:2] != 2'b00 && vk > vb) ? vk : vb; // RL14
    n.irq_n = !ev;
  end
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r <= '0; // RL1
      r.st <= ST_OFF;
      r.ctrl <= CTRL_RST;
      r.lim <= LIM_RST;
      r.dp <= 1'b1;
      r.rdy <= 1'b1;
      r.irq_n <= 1'b1;
      r.vt <= INPUT_VOLTAGE_REGULATION_BASE_DV;
      {r.s1[SI_BTN_N], r.s2[SI_BTN_N], r.s3[SI_BTN_N], r.f[SI_BTN_N]} <= 4'hf; // idle high, no false press
    end else begin
      r <= n;
    end
  end
  assign hreadyout_o = r.rdy;
  assign hrdata_o = r.rd;
  assign hresp_o = r.aw && !r.aw;
  assign gate_drive_regulator_en_o = r.rg;
  assign test_sink_en_o = r.sk;
  assign detect_start_o = r.ds;
  assign buck_en_o = r.bk;
  assign light_load_mode_disable_o = r.ctrl[B_PFMDIS]; // RL15
  assign boost_en_o = r.bo;
  assign battery_switch_on_o = r.sw;
  assign input_current_limit_o = r.lim[F_ICL+:6];
  assign input_voltage_target_o = r.vt;
  assign boost_voltage_o = r.lim[F_OTGV+:4];
  assign boost_current_high_o = r.lim[B_OTGC];
  assign charger_state_code_o = r.csc;
  assign int_n_o = r.irq_n;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  sequence s_chk_end;
    r.st == ST_SRC_CHECK && r.tm >= K_CHK && !lost;
  endsequence

  a_src_good_flags: assert property (s_chk_end ##0 (!ovp && bad) |=> r.sg && r.sgf && !r.irq_n) // RL6
    else $error("source check passed without good flags and interrupt");
  a_src_retry_path: assert property (s_chk_end ##0 (ovp || !bad) |=> r.st == ST_SRC_RETRY && !r.sk) // RL6
    else $error("failed source check did not retry");
  a_gate_drive_regulator_after_wait: assert property ($rose(r.rg) && r.st != ST_BOOST_WAIT |->
    $past(r.st) == ST_GATE_DRIVE_REGULATOR_WAIT && $past(r.tm) >= K_GATE_DRIVE_REGULATOR) // RL5
    else $error("regulator enabled before the wait elapsed");
  a_ocp_opens_switch: assert property (r.st != ST_BUCK && ocp && r.sw |=> !r.sw && r.ctrl[B_DIS]) // RL3
    else $error("overcurrent did not open the battery switch");
  a_buck_after_limit: assert property ($rose(r.bk) |-> $past(r.st, 2) == ST_DETECT) // RL15
    else $error("buck started without the limit step");
  a_boost_code_out: assert property (r.bo |-> r.csc == CSC_BOOST && r.rg) // RL17
    else $error("boost without boost state code");
  a_boost_delay_min: assert property ($rose(r.bo) |-> $past(r.tm) >= K_BOOST) // RL16
    else $error("boost started too early");
  a_btn_timer_restart: assert property (!pr |=> r.bt == '0) // RL26
    else $error("button timer kept counting after release");
  a_wdt_write_restart: assert property (wok |=> r.wd == '0 && !r.ws && !r.wx) // RL19
    else $error("host write did not restart the watchdog");
  a_track_floor_min: assert property (1'b1 |=> r.vt >= $past(vb)) // RL14
    else $error("regulation target below register setting");
  a_auto_limit_hold: assert property (r.st == ST_DETECT && !r.ctrl[B_AUTO] && !wok && !r.wx
    |=> $stable(r.lim)) // RL8
    else $error("limit changed with auto limit off");
endmodule // cps_sequencer
`default_nettype wire

// *** rtl/cps_pkg.sv ***
// charger power-up sequencer: shared constants and types
package cps_pkg;
  localparam int TW = 18;
  // synchronised input indices
  localparam int NSI = 11;
  localparam int SI_UP = 0;
  localparam int SI_SLPF = 1;
  localparam int SI_OVP = 2;
  localparam int SI_BAD = 3;
  localparam int SI_DPL = 4;
  localparam int SI_LBP = 5;
  localparam int SI_OCP = 6;
  localparam int SI_TS = 7;
  localparam int SI_BTN_N = 8;
  localparam int SI_SEL = 9;
  localparam int SI_DET = 10;
  // timing figures, in their own units
  localparam int CLK_PERIOD_NS = 4;
  localparam int MS_NS = 1000000;
  localparam int GATE_DRIVE_REGULATOR_DLY_MS = 220;
  localparam int SRC_CHK_MS = 30;
  localparam int SRC_RETRY_MS = 2000;
  localparam int BOOST_DLY_MS = 30;
  localparam int WDT_BASE_MS = 40000;
  localparam int WDT_WAIT_MS = 512;
  localparam int SHIP_ENTER_MS = 12000;
  localparam int SHIP_EXIT_MS = 1100;
  localparam int BTN_RST_MS = 10000;
  localparam int BSW_RST_MS = 453;
  // register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_LIMIT = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_FLAGS = 8'h0c;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam int B_AUTO = 0;
  localparam int B_DETEN = 1;
  localparam int B_CHGEN = 2;
  localparam int B_PFMDIS = 3;
  localparam int B_OTG = 4;
  localparam int B_HZ = 5;
  localparam int B_DIS = 6;
  localparam int B_DLY = 7;
  localparam int B_RSTEN = 8;
  localparam int B_WDRST = 9;
  localparam int B_REGRST = 10;
  localparam int F_ICL = 0;
  localparam int F_INPUT_VOLTAGE_REGULATION = 8;
  localparam int F_TRK = 12;
  localparam int F_WDP = 16;
  localparam int F_OTGV = 20;
  localparam int B_OTGC = 24;
  localparam int B_SG = 0;
  localparam int B_CR = 1;
  localparam int B_WDS = 2;
  localparam int B_SHIP = 3;
  localparam int F_PORT = 4;
  localparam int F_CSC = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0107;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_01ff;
  localparam logic [31:0] WDT_CTRL_MASK = 32'h0000_003c;
  localparam logic [31:0] LIM_RST = 32'h0121_0609;
  localparam logic [31:0] LIM_WMASK = 32'h01f3_3f3f;
  // 3.9 V floor in 0.1 V units
  localparam logic [6:0] INPUT_VOLTAGE_REGULATION_BASE_DV = 7'h27;
  // limit codes (50 mA per step, code 0 = 50 mA) for detected types 7..0
  localparam logic [47:0] DET_ICL = {6'h2f, 6'h1d, 6'h09, 6'h09, 6'h2f, 6'h13, 6'h27, 6'h29};
  localparam logic PORT_DET_MSB = 1'b1;
  localparam logic [5:0] ICL_SEL_HI = 6'h09;
  localparam logic [5:0] ICL_SEL_LO = 6'h2f;
  localparam logic [3:0] PORT_SEL_HI = 4'hd;
  localparam logic [3:0] PORT_SEL_LO = 4'hf;
  localparam logic [3:0] CSC_IDLE = 4'h0;
  localparam logic [3:0] CSC_BUCK = 4'h1;
  localparam logic [3:0] CSC_BOOST = 4'hf;
  typedef enum logic [8:0] {
    ST_OFF = 9'b0_0000_0001,
    ST_GATE_DRIVE_REGULATOR_WAIT = 9'b0_0000_0010,
    ST_SRC_CHECK = 9'b0_0000_0100,
    ST_SRC_RETRY = 9'b0_0000_1000,
    ST_DETECT = 9'b0_0001_0000,
    ST_INPUT_VOLTAGE_REGULATION = 9'b0_0010_0000,
    ST_BUCK = 9'b0_0100_0000,
    ST_BOOST_WAIT = 9'b0_1000_0000,
    ST_BOOST = 9'b1_0000_0000
  } cps_state_e;
endpackage

// *** bench/cps_detect_model.sv ***
// data-line detection front end answering the sequencer's start request
`timescale 1ns/1ns
`default_nettype none
module cps_detect_model (
  input wire logic clock_i,
  input wire logic start_i,
  input wire logic [2:0] type_i,
  input wire logic [7:0] delay_i,
  output logic done_o,
  output logic [2:0] type_o
);
  logic [7:0] cnt;
  initial begin
    cnt = 8'h00;
    done_o = 1'b0;
    type_o = 3'h0;
  end
  always @(posedge clock_i) begin
    if (!start_i) begin
      cnt <= 8'h00;
      done_o <= 1'b0;
      // released result must not look valid
      type_o <= ~type_o;
    end else if (cnt == delay_i) begin
      done_o <= 1'b1;
      type_o <= type_i;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule // cps_detect_model
`default_nettype wire

// *** bench/tb_top.sv ***
// testbench for the charger power-up sequencer
`timescale 1ns/1ns
`default_nettype none
module tb_top import cps_pkg::*;;
  logic clock_i, nrst_i, hsel_i, hwrite_i, hreadyout_o, hresp_o;
  logic [1:0] htrans_i;
  logic [2:0] hsize_i, dtype, mtype;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, q;
  logic up, slpf, ovp, bad, dpl, lbp, ocp, ts, btn_n, sel, ddone;
  logic gate_drive_regulator, sink, dstart, buck, llm, boost, bsw, bc, int_n;
  logic [5:0] icl;
  logic [6:0] bvolt, tgt;
  logic [3:0] bv, csc;
  logic [7:0] mdly;
  int error_cnt, checks_done, ints, n;
  int ma [8] = '{2100, 2000, 1000, 2400, 500, 500, 1500, 2400};

  cps_sequencer #(.CYC_PER_MS(18'h0_0004), .RETRY_MS(18'h0_0005), .SHIP_MS(18'h0_0006),
    .BRST_MS(18'h0_04b0), .WDT_MS(18'h0_0032)) cps_sequencer_inst (
    .clock_i(clock_i), .nrst_i(nrst_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
    .hreadyout_o(hreadyout_o), .hrdata_o(hrdata_o), .hresp_o(hresp_o),
    .supply_above_sleep_i(up), .supply_below_sleep_fall_i(slpf), .supply_overvoltage_i(ovp),
    .supply_above_bad_adapter_i(bad), .battery_above_depletion_i(dpl), .battery_above_low_i(lbp),
    .discharge_overcurrent_i(ocp), .thermistor_in_range_i(ts), .push_button_pin_n_i(btn_n),
    .select_pin_i(sel), .detect_done_i(ddone), .detect_type_i(dtype), .battery_voltage_i(bvolt),
    .gate_drive_regulator_en_o(gate_drive_regulator), .test_sink_en_o(sink), .detect_start_o(dstart),
    .buck_en_o(buck), .light_load_mode_disable_o(llm), .boost_en_o(boost),
    .battery_switch_on_o(bsw), .input_current_limit_o(icl), .input_voltage_target_o(tgt),
    .boost_voltage_o(bv), .boost_current_high_o(bc), .charger_state_code_o(csc), .int_n_o(int_n));

  cps_detect_model cps_detect_model_inst (.clock_i(clock_i), .start_i(dstart), .type_i(mtype),
    .delay_i(mdly), .done_o(ddone), .type_o(dtype));

  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  always @(negedge int_n) ints++;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one single word transfer; waits on hready, never on a fixed count
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    htrans_i <= 2'h2;
    haddr_i <= {24'h00_0000, a};
    hwrite_i <= w;
    do @(posedge clock_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge clock_i); while (hreadyout_o !== 1'b1);
    q = hrdata_o;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(a, 1'b0, 32'h0000_0000);
    chk(q & m, e);
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clock_i);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // whole run is about 22k cycles
  initial begin
    #240000;
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    {nrst_i, htrans_i, hwrite_i, haddr_i, hwdata_i, up, slpf, ovp, bad, dpl, lbp, ocp, ts, sel} = '0;
    {hsel_i, btn_n} = 2'h3;
    hsize_i = HSIZE_WORD;
    bvolt = 7'h1e;
    mtype = 3'h7;
    mdly = 8'h05;
    cyc(6);
    nrst_i <= 1'b1;
    cyc(3);
    chk(32'(icl), 32'h0000_0009);
    chk(32'(tgt), 32'h0000_002d);
    rdc(REG_CTRL, '1, 32'h0000_0107);
    rdc(REG_LIMIT, '1, 32'h0121_0609);
    rdc(8'h10, '1, 32'h0000_0000);
    chk(32'(hresp_o), 32'h0000_0000);
    chk(32'(bsw), 32'h0000_0000);
    dpl <= 1'b1;
    cyc(8);
    chk(32'({bsw, gate_drive_regulator}), 32'h0000_0002);
    ocp <= 1'b1;
    cyc(8);
    ocp <= 1'b0;
    rdc(REG_STATUS, 32'h0000_0008, 32'h0000_0008);
    chk(32'(bsw), 32'h0000_0000);
    bus(REG_CTRL, 1'b1, 32'h0000_0507);
    cyc(4);
    chk(32'(bsw), 32'h0000_0001);
    bus(REG_CTRL, 1'b1, 32'h0000_0147);
    cyc(2);
    chk(32'(bsw), 32'h0000_0000);
    bus(REG_CTRL, 1'b1, 32'h0000_0107);
    cyc(2);
    chk(32'(bsw), 32'h0000_0001);
    bus(REG_CTRL, 1'b1, 32'h0000_0187);
    cyc(16);
    chk(32'(bsw), 32'h0000_0001);
    for (n = 0; n < 60 && bsw !== 1'b0; n++) @(posedge clock_i);
    chk(32'(bsw), 32'h0000_0000);
    // two presses, each shorter than the exit time
    repeat (2) begin
      btn_n <= 1'b0;
      cyc(3600);
      btn_n <= 1'b1;
      cyc(8);
    end
    chk(32'(bsw), 32'h0000_0000);
    btn_n <= 1'b0;
    for (n = 0; n < 4800 && bsw !== 1'b1; n++) @(posedge clock_i);
    chk(32'((n + 50) / 100), 32'h0000_002c);
    btn_n <= 1'b1;
    cyc(8);
    btn_n <= 1'b0;
    cyc(4600);
    chk(32'(bsw), 32'h0000_0001);
    for (n = 0; n < 400 && bsw !== 1'b0; n++) @(posedge clock_i);
    chk(32'(bsw), 32'h0000_0000);
    btn_n <= 1'b1;
    cyc(1700);
    chk(32'(bsw), 32'h0000_0000);
    for (n = 0; n < 300 && bsw !== 1'b1; n++) @(posedge clock_i);
    chk(32'(bsw), 32'h0000_0001);
    // supply attach, first with a weak source
    bus(REG_LIMIT, 1'b1, 32'h0120_0609);
    ints = 0;
    up <= 1'b1;
    cyc(800);
    chk(32'(gate_drive_regulator), 32'h0000_0000);
    for (n = 0; n < 200 && gate_drive_regulator !== 1'b1; n++) @(posedge clock_i);
    cyc(10);
    chk(32'({gate_drive_regulator, sink, buck}), 32'h0000_0006);
    cyc(200);
    chk(32'(buck), 32'h0000_0000);
    bad <= 1'b1;
    for (n = 0; n < 400 && buck !== 1'b1; n++) @(posedge clock_i);
    chk(32'({dstart, buck, csc}), 32'h0000_0011);
    rdc(REG_STATUS, 32'h0000_0fff, 32'h0000_01f3);
    chk(32'(icl), 32'h0000_002f);
    chk(32'(ints), 32'h0000_0002);
    for (int k = 0; k < 8; k++) begin
      mtype <= k[2:0];
      mdly <= 8'(k * 3);
      bus(REG_CTRL, 1'b1, 32'h0000_0105);
      bus(REG_CTRL, 1'b1, 32'h0000_0107);
      cyc(40);
      chk(32'(icl), 32'(ma[k] / 50 - 1));
      rdc(REG_STATUS, 32'h0000_00f0, {24'h00_0000, 1'b1, k[2:0], 4'h0});
    end
    bus(REG_LIMIT, 1'b1, 32'h0120_0603);
    bus(REG_CTRL, 1'b1, 32'h0000_010c);
    bus(REG_CTRL, 1'b1, 32'h0000_010e);
    cyc(40);
    chk(32'({llm, icl}), 32'h0000_0043);
    rdc(REG_STATUS, 32'h0000_00f0, 32'h0000_00f0);
    bus(REG_CTRL, 1'b1, 32'h0000_010a);
    cyc(4);
    chk(32'(bsw), 32'h0000_0000);
    bus(REG_CTRL, 1'b1, 32'h0000_0107);
    bvolt <= 7'h28;
    bus(REG_LIMIT, 1'b1, 32'h0120_3003);
    cyc(4);
    chk(32'({bsw, tgt}), 32'h0000_00ab);
    bvolt <= 7'h1e;
    cyc(4);
    chk(32'(tgt), 32'h0000_0027);
    bus(REG_CTRL, 1'b1, 32'h0000_0127);
    cyc(2);
    chk(32'({gate_drive_regulator, buck}), 32'h0000_0000);
    bus(REG_CTRL, 1'b1, 32'h0000_0107);
    {up, slpf, lbp, ts} <= 4'h7;
    cyc(20);
    chk(32'({gate_drive_regulator, buck}), 32'h0000_0000);
    bus(REG_CTRL, 1'b1, 32'h0000_0117);
    cyc(100);
    chk(32'(boost), 32'h0000_0000);
    for (n = 0; n < 100 && boost !== 1'b1; n++) @(posedge clock_i);
    chk(32'({boost, gate_drive_regulator, csc, bv, bc}), 32'h0000_07e5);
    lbp <= 1'b0;
    cyc(12);
    chk(32'({boost, csc}), 32'h0000_0000);
    bus(REG_CTRL, 1'b1, 32'h0000_010b);
    bus(REG_LIMIT, 1'b1, 32'h0121_3003);
    ints = 0;
    cyc(180);
    rdc(REG_STATUS, 32'h0000_0004, 32'h0000_0000);
    cyc(40);
    rdc(REG_STATUS, 32'h0000_0004, 32'h0000_0004);
    chk(32'(ints), 32'h0000_0001);
    cyc(1900);
    rdc(REG_LIMIT, '1, 32'h0121_3003);
    cyc(200);
    rdc(REG_LIMIT, '1, 32'h0121_0609);
    rdc(REG_CTRL, '1, 32'h0000_0107);
    rdc(REG_FLAGS, '1, 32'h0000_0007);
    bus(REG_FLAGS, 1'b1, 32'h0000_0007);
    rdc(REG_FLAGS, '1, 32'h0000_0000);
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
